/* design/cache_tlb_debug_readout.sv */
`timescale 1ns/100ps

// How it works
// - Accept only secure privileged readout operations.
// - Other modes get undefined-instruction, no readout.
// - Two read-only results at opcode2 0, 1.
// - Decode five write-only select operations.
// - Data cache readout addresses four ways.
// - Data set width is log2(size/4).
// - Data select: way 31:30, set S+4:5.
// - Data word offset in bits 4:2.
// - Data tag goes to low result only.
// - Coherency state split: 31:29 and 0.
// - Nonsecure 28, tag 27:6, outer 2:1.
// - Data word read returns in low result.
// - Instruction set width is log2(size/2).
// - Instruction tag: valid, nonsecure, address fields.
// - Instruction data: two halfwords, low/high results.
// - Translation descriptor split over both results.
module cache_tlb_debug_readout #(
  parameter int DCACHE_BYTES = readout_pkg::DEFAULT_CACHE_BYTES,
  parameter int ICACHE_BYTES = readout_pkg::DEFAULT_CACHE_BYTES,
  parameter int TRANSLATION_ENTRIES = readout_pkg::DEFAULT_TRANSLATION_ENTRIES,
  localparam int DS = $clog2(DCACHE_BYTES / readout_pkg::DCACHE_WAYS),
  localparam int IS = $clog2(ICACHE_BYTES / readout_pkg::ICACHE_WAYS),
  localparam int TS = $clog2(TRANSLATION_ENTRIES / readout_pkg::TRANSLATION_WAYS)
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cp_valid_in,
  input wire logic cp_write_in,
  input wire logic [2:0] cp_opc1_in,
  input wire logic [3:0] cp_crn_in,
  input wire logic [3:0] cp_crm_in,
  input wire logic [2:0] cp_opc2_in,
  input wire logic [31:0] cp_wdata_in,
  input wire logic cp_secure_in,
  input wire logic cp_privileged_in,
  output logic cp_ready_out,
  output logic cp_ack_out,
  output logic cp_undef_out,
  output logic [31:0] cp_rdata_out,
  output logic dtag_rd_out,
  output logic dc_data_rd_out,
  output logic [1:0] dc_way_out,
  output logic [DS-1:0] dc_set_out,
  output logic [2:0] dc_word_out,
  input wire logic [3:0] dtag_state_in,
  input wire logic dtag_nonsecure_flag_in,
  input wire logic [21:0] dtag_addr_in,
  input wire logic [1:0] dtag_outer_in,
  input wire logic [31:0] dc_word_in,
  output logic itag_rd_out,
  output logic ic_data_rd_out,
  output logic ic_way_out,
  output logic [IS-1:0] ic_set_out,
  output logic [3:0] ic_half_out,
  input wire logic [1:0] itag_valid_in,
  input wire logic itag_nonsecure_flag_in,
  input wire logic [20:0] itag_addr_in,
  input wire logic [31:0] ic_pair_in,
  output logic translation_cache_rd_out,
  output logic translation_cache_way_out,
  output logic [TS-1:0] translation_cache_index_out,
  input wire logic [62:0] translation_desc_in
);

  // ===========================================================================
  // State.
  // ===========================================================================
  typedef enum {ST_IDLE, ST_WAIT, ST_CAPTURE} readout_state_t;

  readout_state_t state_r, state_nxt;
  readout_pkg::readout_kind_t kind_r, kind_nxt;
  logic ready_r, ready_nxt;
  logic ack_r, ack_nxt;
  logic undef_r, undef_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] result_low_r, result_low_nxt;
  logic [31:0] result_high_r, result_high_nxt;
  logic dtag_rd_r, dtag_rd_nxt;
  logic dc_data_rd_r, dc_data_rd_nxt;
  logic itag_rd_r, itag_rd_nxt;
  logic ic_data_rd_r, ic_data_rd_nxt;
  logic tc_rd_r, tc_rd_nxt;
  logic [1:0] dc_way_r, dc_way_nxt;
  logic [DS-1:0] dc_set_r, dc_set_nxt;
  logic [2:0] dc_word_r, dc_word_nxt;
  logic ic_way_r, ic_way_nxt;
  logic [IS-1:0] ic_set_r, ic_set_nxt;
  logic [3:0] ic_half_r, ic_half_nxt;
  logic tc_way_r, tc_way_nxt;
  logic [TS-1:0] tc_index_r, tc_index_nxt;
  logic [31:0] packed_low;
  logic [31:0] packed_high;
  logic op_hit;
  logic op_allowed;

  // ===========================================================================
  // Result formatting of the array data that is valid in the capture cycle.
  // ===========================================================================
  readout_packer u_packer (
    .kind_in(kind_r),
    .dtag_state_in(dtag_state_in),
    .dtag_nonsecure_flag_in(dtag_nonsecure_flag_in),
    .dtag_addr_in(dtag_addr_in),
    .dtag_outer_in(dtag_outer_in),
    .dc_word_in(dc_word_in),
    .itag_valid_in(itag_valid_in),
    .itag_nonsecure_flag_in(itag_nonsecure_flag_in),
    .itag_addr_in(itag_addr_in),
    .ic_pair_in(ic_pair_in),
    .translation_desc_in(translation_desc_in),
    .result_low_out(packed_low),
    .result_high_out(packed_high)
  );

  // ===========================================================================
  // Operation decode and sequencing.
  // ===========================================================================
  // Operations outside this block's coprocessor space are left to other logic and get no answer.
  assign op_hit = cp_valid_in && ready_r && (cp_opc1_in == readout_pkg::OPC1_READOUT) &&
                  (cp_crn_in == readout_pkg::CRN_READOUT);
  assign op_allowed = cp_secure_in && cp_privileged_in;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    ack_nxt = 1'b0;
    undef_nxt = 1'b0;
    rdata_nxt = rdata_r;
    result_low_nxt = result_low_r;
    result_high_nxt = result_high_r;
    dtag_rd_nxt = 1'b0;
    dc_data_rd_nxt = 1'b0;
    itag_rd_nxt = 1'b0;
    ic_data_rd_nxt = 1'b0;
    tc_rd_nxt = 1'b0;
    dc_way_nxt = dc_way_r;
    dc_set_nxt = dc_set_r;
    dc_word_nxt = dc_word_r;
    ic_way_nxt = ic_way_r;
    ic_set_nxt = ic_set_r;
    ic_half_nxt = ic_half_r;
    tc_way_nxt = tc_way_r;
    tc_index_nxt = tc_index_r;
    unique case (state_r)
      ST_IDLE: begin
        if (op_hit) begin
          ack_nxt = 1'b1;
          if (!op_allowed) begin
            undef_nxt = 1'b1;
          end else if (!cp_write_in) begin
            if (cp_crm_in == readout_pkg::CRM_RESULT &&
                cp_opc2_in == readout_pkg::OPC2_RESULT_LOW) begin
              rdata_nxt = result_low_r;
            end else if (cp_crm_in == readout_pkg::CRM_RESULT &&
                         cp_opc2_in == readout_pkg::OPC2_RESULT_HIGH) begin
              rdata_nxt = result_high_r;
            end else begin
              undef_nxt = 1'b1;
            end
          end else begin
            // Every select loads all location fields; only the chosen array is strobed.
            dc_way_nxt = cp_wdata_in[readout_pkg::SEL_DC_WAY_LO +: 2];
            dc_set_nxt = cp_wdata_in[readout_pkg::SEL_SET_LO +: DS];
            dc_word_nxt = cp_wdata_in[readout_pkg::SEL_WORD_LO +: readout_pkg::SEL_WORD_W];
            ic_way_nxt = cp_wdata_in[readout_pkg::SEL_WAY_BIT];
            ic_set_nxt = cp_wdata_in[readout_pkg::SEL_SET_LO +: IS];
            ic_half_nxt = cp_wdata_in[readout_pkg::SEL_HALF_LO +: readout_pkg::SEL_HALF_W];
            tc_way_nxt = cp_wdata_in[readout_pkg::SEL_WAY_BIT];
            tc_index_nxt = cp_wdata_in[TS-1:0];
            ack_nxt = 1'b0;
            state_nxt = ST_WAIT;
            if (cp_crm_in == readout_pkg::CRM_TAG_SEL &&
                cp_opc2_in == readout_pkg::OPC2_DCACHE) begin
              kind_nxt = readout_pkg::KIND_DTAG;
              dtag_rd_nxt = 1'b1;
            end else if (cp_crm_in == readout_pkg::CRM_TAG_SEL &&
                         cp_opc2_in == readout_pkg::OPC2_ICACHE) begin
              kind_nxt = readout_pkg::KIND_ITAG;
              itag_rd_nxt = 1'b1;
            end else if (cp_crm_in == readout_pkg::CRM_DATA_SEL &&
                         cp_opc2_in == readout_pkg::OPC2_DCACHE) begin
              kind_nxt = readout_pkg::KIND_DDATA;
              dc_data_rd_nxt = 1'b1;
            end else if (cp_crm_in == readout_pkg::CRM_DATA_SEL &&
                         cp_opc2_in == readout_pkg::OPC2_ICACHE) begin
              kind_nxt = readout_pkg::KIND_IDATA;
              ic_data_rd_nxt = 1'b1;
            end else if (cp_crm_in == readout_pkg::CRM_DATA_SEL &&
                         cp_opc2_in == readout_pkg::OPC2_TRANSLATION) begin
              kind_nxt = readout_pkg::KIND_TRANSLATION;
              tc_rd_nxt = 1'b1;
            end else begin
              ack_nxt = 1'b1;
              undef_nxt = 1'b1;
              state_nxt = ST_IDLE;
            end
          end
        end
      end
      ST_WAIT: begin
        state_nxt = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        // Tag reads clear the high result so stale data cannot be mistaken for tag state.
        result_low_nxt = packed_low;
        result_high_nxt = packed_high;
        ack_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      kind_r <= readout_pkg::KIND_DTAG;
      ready_r <= 1'b0;
      ack_r <= 1'b0;
      undef_r <= 1'b0;
      rdata_r <= readout_pkg::RESULT_RESET;
      result_low_r <= readout_pkg::RESULT_RESET;
      result_high_r <= readout_pkg::RESULT_RESET;
      dtag_rd_r <= 1'b0;
      dc_data_rd_r <= 1'b0;
      itag_rd_r <= 1'b0;
      ic_data_rd_r <= 1'b0;
      tc_rd_r <= 1'b0;
      dc_way_r <= '0;
      dc_set_r <= '0;
      dc_word_r <= '0;
      ic_way_r <= 1'b0;
      ic_set_r <= '0;
      ic_half_r <= '0;
      tc_way_r <= 1'b0;
      tc_index_r <= '0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      ready_r <= ready_nxt;
      ack_r <= ack_nxt;
      undef_r <= undef_nxt;
      rdata_r <= rdata_nxt;
      result_low_r <= result_low_nxt;
      result_high_r <= result_high_nxt;
      dtag_rd_r <= dtag_rd_nxt;
      dc_data_rd_r <= dc_data_rd_nxt;
      itag_rd_r <= itag_rd_nxt;
      ic_data_rd_r <= ic_data_rd_nxt;
      tc_rd_r <= tc_rd_nxt;
      dc_way_r <= dc_way_nxt;
      dc_set_r <= dc_set_nxt;
      dc_word_r <= dc_word_nxt;
      ic_way_r <= ic_way_nxt;
      ic_set_r <= ic_set_nxt;
      ic_half_r <= ic_half_nxt;
      tc_way_r <= tc_way_nxt;
      tc_index_r <= tc_index_nxt;
    end
  end

  // ===========================================================================
  // Outputs.
  // ===========================================================================
  assign cp_ready_out = ready_r;
  assign cp_ack_out = ack_r;
  assign cp_undef_out = undef_r;
  assign cp_rdata_out = rdata_r;
  assign dtag_rd_out = dtag_rd_r;
  assign dc_data_rd_out = dc_data_rd_r;
  assign dc_way_out = dc_way_r;
  assign dc_set_out = dc_set_r;
  assign dc_word_out = dc_word_r;
  assign itag_rd_out = itag_rd_r;
  assign ic_data_rd_out = ic_data_rd_r;
  assign ic_way_out = ic_way_r;
  assign ic_set_out = ic_set_r;
  assign ic_half_out = ic_half_r;
  assign translation_cache_rd_out = tc_rd_r;
  assign translation_cache_way_out = tc_way_r;
  assign translation_cache_index_out = tc_index_r;

endmodule : cache_tlb_debug_readout

/* design/readout_pkg.sv */
package readout_pkg;

  // ===========================================================================
  // Coprocessor operation space of the debug readout.
  // ===========================================================================
  localparam logic [2:0] OPC1_READOUT = 3'h3;
  localparam logic [3:0] CRN_READOUT = 4'hF;
  localparam logic [3:0] CRM_RESULT = 4'h0;
  localparam logic [3:0] CRM_TAG_SEL = 4'h2;
  localparam logic [3:0] CRM_DATA_SEL = 4'h4;
  localparam logic [2:0] OPC2_RESULT_LOW = 3'h0;
  localparam logic [2:0] OPC2_RESULT_HIGH = 3'h1;
  localparam logic [2:0] OPC2_DCACHE = 3'h0;
  localparam logic [2:0] OPC2_ICACHE = 3'h1;
  localparam logic [2:0] OPC2_TRANSLATION = 3'h2;

  // ===========================================================================
  // Array geometry.
  // ===========================================================================
  localparam int DCACHE_WAYS = 4;
  localparam int ICACHE_WAYS = 2;
  localparam int TRANSLATION_WAYS = 2;
  localparam int DEFAULT_CACHE_BYTES = 32768;
  localparam int DEFAULT_TRANSLATION_ENTRIES = 128;
  localparam int TRANSLATION_DESC_W = 63;

  // ===========================================================================
  // Select word field positions.
  // ===========================================================================
  localparam int SEL_DC_WAY_LO = 30;
  localparam int SEL_WAY_BIT = 31;
  localparam int SEL_SET_LO = 5;
  localparam int SEL_WORD_LO = 2;
  localparam int SEL_WORD_W = 3;
  localparam int SEL_HALF_LO = 1;
  localparam int SEL_HALF_W = 4;

  // ===========================================================================
  // Result word field positions.
  // ===========================================================================
  localparam int DTAG_STATE_HI_LO = 29;
  localparam int DTAG_NS_BIT = 28;
  localparam int DTAG_ADDR_LO = 6;
  localparam int DTAG_ADDR_W = 22;
  localparam int DTAG_OUTER_LO = 1;
  localparam int DTAG_STATE_LSB = 0;
  localparam int ITAG_VALID_LO = 22;
  localparam int ITAG_NS_BIT = 21;
  localparam int ITAG_ADDR_W = 21;
  localparam int HALF_W = 16;

  localparam logic [31:0] RESULT_RESET = 32'h00000000;

  // A four-state base type lets the kind travel on a net port into the result packer.
  typedef enum logic [2:0] {
    KIND_DTAG,
    KIND_ITAG,
    KIND_DDATA,
    KIND_IDATA,
    KIND_TRANSLATION
  } readout_kind_t;

endpackage : readout_pkg

/* design/readout_packer.sv */
`timescale 1ns/100ps

module readout_packer (
  input wire readout_pkg::readout_kind_t kind_in,
  input wire logic [3:0] dtag_state_in,
  input wire logic dtag_nonsecure_flag_in,
  input wire logic [21:0] dtag_addr_in,
  input wire logic [1:0] dtag_outer_in,
  input wire logic [31:0] dc_word_in,
  input wire logic [1:0] itag_valid_in,
  input wire logic itag_nonsecure_flag_in,
  input wire logic [20:0] itag_addr_in,
  input wire logic [31:0] ic_pair_in,
  input wire logic [62:0] translation_desc_in,
  output logic [31:0] result_low_out,
  output logic [31:0] result_high_out
);

  // ===========================================================================
  // Result formatting.
  // ===========================================================================
  always_comb begin
    result_low_out = readout_pkg::RESULT_RESET;
    result_high_out = readout_pkg::RESULT_RESET;
    unique case (kind_in)
      readout_pkg::KIND_DTAG: begin
        // The coherency state is split around the tag fields.
        result_low_out[readout_pkg::DTAG_STATE_HI_LO +: 3] = dtag_state_in[3:1];
        result_low_out[readout_pkg::DTAG_STATE_LSB] = dtag_state_in[0];
        result_low_out[readout_pkg::DTAG_NS_BIT] = dtag_nonsecure_flag_in;
        result_low_out[readout_pkg::DTAG_ADDR_LO +: readout_pkg::DTAG_ADDR_W] =
          dtag_addr_in;
        result_low_out[readout_pkg::DTAG_OUTER_LO +: 2] = dtag_outer_in;
      end
      readout_pkg::KIND_ITAG: begin
        result_low_out[readout_pkg::ITAG_VALID_LO +: 2] = itag_valid_in;
        result_low_out[readout_pkg::ITAG_NS_BIT] = itag_nonsecure_flag_in;
        result_low_out[readout_pkg::ITAG_ADDR_W - 1:0] = itag_addr_in;
      end
      readout_pkg::KIND_DDATA: begin
        result_low_out = dc_word_in;
      end
      readout_pkg::KIND_IDATA: begin
        result_low_out[readout_pkg::HALF_W - 1:0] = ic_pair_in[15:0];
        result_high_out[readout_pkg::HALF_W - 1:0] = ic_pair_in[31:16];
      end
      readout_pkg::KIND_TRANSLATION: begin
        result_low_out = translation_desc_in[31:0];
        result_high_out = {1'b0, translation_desc_in[62:32]};
      end
    endcase
  end

endmodule : readout_packer

/* test/cache_arrays_model.sv */
`timescale 1ns/100ps

// =====
// Array model.
// =====
// Data is valid only in the cycle after a read strobe. At other times the
// outputs show the inverse, so an early or late sample is caught.
module cache_arrays_model (
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic [17:0] dl_in,
  input wire logic [18:0] il_in,
  input wire logic [6:0] tl_in,
  output logic [28:0] dtag_out,
  output logic [31:0] dword_out,
  output logic [23:0] itag_out,
  output logic [31:0] ipair_out,
  output logic [62:0] desc_out
);
  logic live_r;
  logic live_nxt;

  always_comb begin
    live_nxt = rd_in;
    dtag_out = {dl_in[3:0], dl_in[17], 4'hC, dl_in, dl_in[17:16]};
    dword_out = {14'h2A5B, dl_in};
    itag_out = {il_in[1:0], il_in[18], 2'h1, il_in};
    ipair_out = {13'h1ABC, il_in};
    desc_out = {tl_in, 49'h1_2345_6789_ABCD, tl_in};
    if (live_r !== 1'h1) begin
      {dtag_out, dword_out, itag_out} = ~{dtag_out, dword_out, itag_out};
      {ipair_out, desc_out} = ~{ipair_out, desc_out};
    end
  end

  always_ff @(posedge clk_in) begin
    live_r <= live_nxt;
  end
endmodule : cache_arrays_model

/* test/readout_chk.sv */
`timescale 1ns/100ps

// =====
// Port checker.
// =====
module readout_chk #(
  parameter int DCACHE_BYTES = 32768,
  parameter int ICACHE_BYTES = 32768,
  localparam int DS = $clog2(DCACHE_BYTES / 4),
  localparam int IS = $clog2(ICACHE_BYTES / 2)
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic cp_valid_in,
  input wire logic cp_write_in,
  input wire logic [2:0] cp_opc1_in,
  input wire logic [3:0] cp_crn_in,
  input wire logic [3:0] cp_crm_in,
  input wire logic [2:0] cp_opc2_in,
  input wire logic [31:0] cp_wdata_in,
  input wire logic cp_secure_in,
  input wire logic cp_privileged_in,
  input wire logic cp_ready_out,
  input wire logic cp_ack_out,
  input wire logic cp_undef_out,
  input wire logic [31:0] cp_rdata_out,
  input wire logic dtag_rd_out,
  input wire logic dc_data_rd_out,
  input wire logic itag_rd_out,
  input wire logic ic_data_rd_out,
  input wire logic translation_cache_rd_out,
  input wire logic [1:0] dc_way_out,
  input wire logic [DS-1:0] dc_set_out,
  input wire logic [2:0] dc_word_out,
  input wire logic ic_way_out,
  input wire logic [IS-1:0] ic_set_out,
  input wire logic [3:0] ic_half_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic take, ok, strobe, rd_ok, g_sel, g_rd;
  logic [DS+4:0] dloc;
  logic [IS+4:0] iloc;
  assign take = cp_valid_in && cp_ready_out && cp_opc1_in == 3'h3 && cp_crn_in == 4'hF;
  assign ok = cp_secure_in && cp_privileged_in;
  assign strobe = dtag_rd_out || dc_data_rd_out || itag_rd_out || ic_data_rd_out
    || translation_cache_rd_out;
  assign rd_ok = cp_crm_in == 4'h0 && cp_opc2_in <= 3'h1;
  assign g_sel = take && cp_write_in && ok;
  assign g_rd = take && !cp_write_in;
  assign dloc = {cp_wdata_in[31:30], cp_wdata_in[DS+4:2]};
  assign iloc = {cp_wdata_in[31], cp_wdata_in[IS+4:1]};

  sequence s_busy;
    !cp_ready_out && !cp_ack_out;
  endsequence
  sequence s_done;
    cp_ready_out && cp_ack_out && !cp_undef_out;
  endsequence

  a_strobe_cause: assert property (strobe |-> $past(g_sel))
    else $error("array strobe without a granted select");
  a_refused_undef: assert property (take && !ok |=>
    cp_ack_out && cp_undef_out && !strobe)
    else $error("refused operation not answered as undefined");
  a_select_timing: assert property (strobe |-> s_busy ##1 s_busy ##1 s_done)
    else $error("select answer timing wrong");
  a_read_answer: assert property (g_rd && ok && rd_ok |=> cp_ack_out && !cp_undef_out)
    else $error("result read not answered");
  a_bad_read: assert property (g_rd && !rd_ok |=> cp_ack_out && cp_undef_out)
    else $error("unknown read not undefined");
  a_dc_location: assert property (dtag_rd_out || dc_data_rd_out |->
    {dc_way_out, dc_set_out, dc_word_out} == $past(dloc))
    else $error("data cache location wrong");
  a_ic_location: assert property (itag_rd_out || ic_data_rd_out |->
    {ic_way_out, ic_set_out, ic_half_out} == $past(iloc))
    else $error("instruction cache location wrong");
  a_rdata_hold: assert property (!$past(sys_rst_in) && !$past(g_rd) |->
    $stable(cp_rdata_out))
    else $error("read data changed without a read");
  a_undef_paired: assert property (cp_undef_out |-> cp_ack_out)
    else $error("undefined flag without answer");
endmodule : readout_chk

bind cache_tlb_debug_readout readout_chk #(.DCACHE_BYTES(DCACHE_BYTES),
  .ICACHE_BYTES(ICACHE_BYTES)) i_readout_chk (.*);

/* test/testbench.sv */
`timescale 1ns/100ps

// =====
// Readout bench.
// =====
module testbench;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic cp_valid_in = 1'h0;
  logic cp_write_in = 1'h0;
  logic cp_secure_in = 1'h1;
  logic cp_privileged_in = 1'h1;
  logic [2:0] cp_opc1_in = 3'h3;
  logic [2:0] cp_opc2_in = 3'h0;
  logic [3:0] cp_crn_in = 4'hF;
  logic [3:0] cp_crm_in = 4'h0;
  logic [31:0] cp_wdata_in = 32'h0;
  logic cp_ready_out, cp_ack_out, cp_undef_out, ic_way_out, translation_cache_way_out, und;
  logic dtag_rd_out, dc_data_rd_out, itag_rd_out, ic_data_rd_out, translation_cache_rd_out;
  logic dtag_nonsecure_flag_in, itag_nonsecure_flag_in, any_rd;
  logic [1:0] dc_way_out, dtag_outer_in, itag_valid_in;
  logic [2:0] dc_word_out;
  logic [3:0] ic_half_out, dtag_state_in;
  logic [5:0] translation_cache_index_out;
  logic [12:0] dc_set_out;
  logic [13:0] ic_set_out;
  logic [20:0] itag_addr_in;
  logic [21:0] dtag_addr_in;
  logic [31:0] cp_rdata_out, dc_word_in, ic_pair_in, rd, lo, hi;
  logic [62:0] translation_desc_in;
  logic [28:0] dt;
  logic [23:0] it;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] words [5] = '{32'hFFFF_FFFF, 32'hBFFF_FFFE, 32'h4002_0A0B, 32'h8007_FFE2,
    32'h8000_002A};
  logic [7:0] bad_ops [5] = '{8'h02, 8'h10, 8'h92, 8'hA3, 8'h80};

  assign {dtag_state_in, dtag_nonsecure_flag_in, dtag_addr_in, dtag_outer_in} = dt;
  assign {itag_valid_in, itag_nonsecure_flag_in, itag_addr_in} = it;
  assign any_rd = dtag_rd_out | dc_data_rd_out | itag_rd_out | ic_data_rd_out
    | translation_cache_rd_out;

  cache_tlb_debug_readout i_cache_tlb_debug_readout (.*);
  cache_arrays_model i_cache_arrays_model (
    .clk_in(clk_in),
    .rd_in(any_rd),
    .dl_in({dc_way_out, dc_set_out, dc_word_out}),
    .il_in({ic_way_out, ic_set_out, ic_half_out}),
    .tl_in({translation_cache_way_out, translation_cache_index_out}),
    .dtag_out(dt),
    .dword_out(dc_word_in),
    .itag_out(it),
    .ipair_out(ic_pair_in),
    .desc_out(translation_desc_in)
  );

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // A hung handshake ends the run here; the normal run needs under two hundred cycles.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // The request is held until the edge that samples ready high.
  task automatic op(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
                    input logic [31:0] d, input logic [1:0] mode);
    int n;
    n = 0;
    @(posedge clk_in);
    {cp_write_in, cp_crm_in, cp_opc2_in, cp_wdata_in} <= {wr, crm, opc2, d};
    {cp_secure_in, cp_privileged_in} <= mode;
    cp_valid_in <= 1'h1;
    do @(posedge clk_in); while (cp_ready_out !== 1'h1 && ++n < 20);
    cp_valid_in <= 1'h0;
    do @(posedge clk_in); while (cp_ack_out !== 1'h1 && ++n < 40);
    rd = cp_rdata_out;
    und = cp_undef_out;
    chk({31'h0, cp_ack_out}, 32'h1);
  endtask : op

  task automatic rdres(input logic [2:0] opc2);
    op(1'h0, 4'h0, opc2, 32'h0, 2'h3);
  endtask : rdres

  task automatic sel_test(input int k, input logic [31:0] s);
    logic [17:0] l;
    logic [18:0] m;
    l = {s[31:30], s[17:2]};
    m = {s[31], s[18:1]};
    hi = 32'h0;
    case (k)
      0: lo = {l[3:1], l[17], 4'hC, l, 3'h0, l[17:16], l[0]};
      1: lo = {8'h00, m[1:0], m[18], 2'h1, m};
      2: lo = {14'h2A5B, l};
      3: {hi, lo} = {16'h0, 13'h1ABC, m[18:16], 16'h0, m[15:0]};
      default: {hi, lo} = {1'h0, s[31], s[5:0], 49'h1_2345_6789_ABCD, s[31], s[5:0]};
    endcase
    op(1'h1, (k < 2) ? 4'h2 : 4'h4, 3'((k < 2) ? k : k - 2), s, 2'h3);
    chk({31'h0, und}, 32'h0);
    rdres(3'h0);
    chk(rd, lo);
    rdres(3'h1);
    chk(rd, hi);
    rdres(3'h0);
    chk(rd, lo);
  endtask : sel_test

  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    rdres(3'h1);
    chk(rd, 32'h0);
    for (int k = 0; k < 5; k++) begin
      sel_test(k, words[k]);
    end
    for (int i = 0; i < 3; i++) begin
      op(1'h1, 4'h4, 3'h0, 32'h0, 2'(i));
      chk({31'h0, und}, 32'h1);
      op(1'h0, 4'h0, 3'h1, 32'h0, 2'(i));
      chk({31'h0, und}, 32'h1);
    end
    rdres(3'h1);
    chk(rd, hi);
    foreach (bad_ops[i]) begin
      op(bad_ops[i][7], bad_ops[i][6:3], bad_ops[i][2:0], 32'h0, 2'h3);
      chk({31'h0, und}, 32'h1);
    end
    rdres(3'h0);
    chk(rd, lo);
    @(posedge clk_in);
    cp_crn_in <= 4'hE;
    cp_valid_in <= 1'h1;
    repeat (4) begin
      @(posedge clk_in);
      chk({31'h0, cp_ack_out}, 32'h0);
    end
    cp_valid_in <= 1'h0;
    cp_crn_in <= 4'hF;
    sys_rst_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    rdres(3'h0);
    chk(rd, 32'h0);
    results();
  end
endmodule : testbench
